/* core/ccra_core.sv */
// cpu core: prefetch queue, registers, status word, address generation
//
// What this block does
// - fetch next instruction byte whenever the queue is empty
// - last instruction cycle loads opcode into ir and refills queue
// - empty queue plus operand needed in first cycle: one wait
// - decoder works on queued bytes one cycle before use
// - program counter is 19 bits, lsb picks the half byte
// - after reset program counter comes from vector at 04000
// - two 16-bit pointer registers, word moves, undefined at reset
// - stack pointer marks top byte, push decrements, pop increments
// - four data bytes, undefined at reset, pair as words odd high
// - status word pushed on interrupt, restored on return
// - zero flag set when result is all zero
// - carry flag set on carry out of or borrow into msb
// - negative flag copies result msb
// - overflow flag set on signed overflow
// - maskable level accepted only when below mask level
// - accepted level loads mask field
// - enable bit zero blocks maskable requests; interrupts keep it
// - pointer or stack pointer plus displacement gives data address
// - branch target is pc plus displacement or 18-bit absolute
// - short ram adds offset to zero, short io to special base
// - reuse mode repeats last address, move instructions only
// - decode ram, special registers, rom and rom option areas
// - byte fetches into a two byte queue
`timescale 1ns/1ns
module ccra_core (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_fetch_data,
  input wire logic i_instr_last,
  input wire logic i_need_imm,
  input wire logic i_flush,
  input wire logic [2:0] i_br_mode,
  input wire logic [17:0] i_br_disp,
  input wire logic i_br_h,
  input wire logic i_alu_go,
  input wire logic [2:0] i_alu_op,
  input wire logic i_alu_word,
  input wire logic [15:0] i_src_a,
  input wire logic [15:0] i_src_b,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_sel,
  input wire logic [15:0] i_wr_data,
  input wire logic [3:0] i_rd_sel,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_reti,
  input wire logic [7:0] i_pop_data,
  input wire logic i_irq_req,
  input wire logic [1:0] i_irq_level,
  input wire logic i_nmi_req,
  input wire logic i_ea_go,
  input wire logic [3:0] i_ea_mode,
  input wire logic i_ea_ptr,
  input wire logic i_ea_move,
  input wire logic [15:0] i_ea_disp,
  output logic o_fetch_req,
  output logic [17:0] o_fetch_addr,
  output logic [7:0] o_instr_reg,
  output logic [3:0] o_decode_ctrl,
  output logic o_wait,
  output logic [18:0] o_pc,
  output logic o_boot_done,
  output logic [15:0] o_alu_result,
  output logic [7:0] o_psw,
  output logic [15:0] o_rd_data,
  output logic o_stack_we,
  output logic [15:0] o_stack_addr,
  output logic [7:0] o_stack_wdata,
  output logic o_irq_accept,
  output logic [17:0] o_ea,
  output logic [3:0] o_ea_region,
  output logic o_ea_bad
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  ccra_pkg::ccra_state_type state, next_state;
  logic [1:0] q_count, next_count;
  logic [7:0] q0, q1, next_q0, next_q1, vec_lo;
  logic [18:0] fpc, next_fpc, target, sext;
  logic next_req;
  logic [17:0] next_addr;
  logic [7:0] gp [4];
  logic [15:0] ptr0, ptr1, sp, next_sp, rd_mux, ea16;
  logic [16:0] res;
  logic [7:0] next_psw;
  logic [17:0] next_ea, last_ea;

  // prefetch queue
  wire run = state == ccra_pkg::ST_RUN;
  wire arrive = run && o_fetch_req && !i_flush;
  wire head_ok = (q_count != 2'h0) || arrive;
  wire [7:0] head = (q_count != 2'h0) ? q0 : i_fetch_data;
  wire pop = run && !i_flush && i_instr_last && head_ok;
  wire [1:0] unread = q_count + {1'b0, o_fetch_req};
  wire [18:0] head_addr = fpc - {16'h0000, unread, 1'b0};
  wire next_wait = run && !i_flush && i_need_imm && q_count == 2'h0
    && !o_wait;
  wire [3:0] next_decode = head_ok ? 4'h1 << head[7:6] : 4'h0;

  always_comb
  begin
    next_q0 = q0;
    next_q1 = q1;
    next_count = q_count;
    if (!run || i_flush)
    begin
      next_count = 2'h0;
    end
    else
    begin
      if (pop && q_count != 2'h0)
      begin
        next_q0 = q1;
        next_count = q_count - 2'h1;
      end
      if (arrive && !(pop && q_count == 2'h0))
      begin
        if (next_count == 2'h0)
          next_q0 = i_fetch_data;
        else
          next_q1 = i_fetch_data;
        next_count = next_count + 2'h1;
      end
    end
  end

  // branch target in nibbles
  always_comb
  begin
    case (i_br_mode)
      ccra_pkg::BR_D4: sext = {{15{i_br_disp[3]}}, i_br_disp[3:0]};
      ccra_pkg::BR_D7: sext = {{12{i_br_disp[6]}}, i_br_disp[6:0]};
      ccra_pkg::BR_D11: sext = {{8{i_br_disp[10]}}, i_br_disp[10:0]};
      ccra_pkg::BR_D12: sext = {{7{i_br_disp[11]}}, i_br_disp[11:0]};
      ccra_pkg::BR_D16: sext = {{3{i_br_disp[15]}}, i_br_disp[15:0]};
      default: sext = 19'h00000;
    endcase
    if (i_br_mode == ccra_pkg::BR_ABS18)
      target = {i_br_disp, i_br_h};
    else
      target = o_pc + sext;
  end

  // boot sequence and fetch request
  always_comb
  begin
    next_state = state;
    next_req = 1'b0;
    next_addr = o_fetch_addr;
    next_fpc = fpc;
    case (state)
      ccra_pkg::ST_VEC0:
      begin
        next_req = 1'b1;
        next_addr = ccra_pkg::VEC_ADDR;
        next_state = ccra_pkg::ST_VEC1;
      end
      ccra_pkg::ST_VEC1:
      begin
        next_req = 1'b1;
        next_addr = ccra_pkg::VEC_ADDR + 18'h00001;
        next_state = ccra_pkg::ST_VEC2;
      end
      ccra_pkg::ST_VEC2:
      begin
        next_fpc = {2'h0, i_fetch_data, vec_lo, 1'b0};
        next_state = ccra_pkg::ST_RUN;
      end
      ccra_pkg::ST_RUN:
      begin
        if (i_flush)
        begin
          next_req = 1'b1;
          next_addr = target[18:1];
          next_fpc = target + ccra_pkg::BYTE_NIBBLES;
        end
        else if (next_count < ccra_pkg::QUEUE_DEPTH)
        begin
          next_req = 1'b1;
          next_addr = fpc[18:1];
          next_fpc = fpc + ccra_pkg::BYTE_NIBBLES;
        end
      end
      default: next_state = ccra_pkg::ST_VEC0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state <= ccra_pkg::ST_VEC0;
      q_count <= 2'h0;
      q0 <= 8'h00;
      q1 <= 8'h00;
      o_fetch_req <= 1'b0;
      o_fetch_addr <= 18'h00000;
      fpc <= 19'h00000;
      vec_lo <= 8'h00;
      o_boot_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      q_count <= next_count;
      q0 <= next_q0;
      q1 <= next_q1;
      o_fetch_req <= next_req;
      o_fetch_addr <= next_addr;
      fpc <= next_fpc;
      if (state == ccra_pkg::ST_VEC1)
        vec_lo <= i_fetch_data;
      o_boot_done <= next_state == ccra_pkg::ST_RUN;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_instr_reg <= 8'h00;
      o_decode_ctrl <= 4'h0;
      o_wait <= 1'b0;
      o_pc <= 19'h00000;
    end
    else
    begin
      o_decode_ctrl <= next_decode;
      o_wait <= next_wait;
      if (state == ccra_pkg::ST_VEC2)
        o_pc <= next_fpc;
      else if (pop)
      begin
        o_instr_reg <= head;
        o_pc <= head_addr;
      end
    end
  end

  // alu and flags
  wire [15:0] aw = i_alu_word ? i_src_a : {8'h00, i_src_a[7:0]};
  wire [15:0] bw = i_alu_word ? i_src_b : {8'h00, i_src_b[7:0]};
  wire [16:0] sum = {1'b0, aw} + {1'b0, bw};
  wire [16:0] dif = {1'b0, aw} - {1'b0, bw};
  always_comb
  begin
    case (i_alu_op)
      ccra_pkg::ALU_ADD: res = sum;
      ccra_pkg::ALU_SUB, ccra_pkg::ALU_CMP: res = dif;
      ccra_pkg::ALU_AND: res = {1'b0, aw & bw};
      ccra_pkg::ALU_OR: res = {1'b0, aw | bw};
      ccra_pkg::ALU_XOR: res = {1'b0, aw ^ bw};
      default: res = {1'b0, bw};
    endcase
  end
  wire [15:0] res16 = i_alu_word ? res[15:0] : {8'h00, res[7:0]};
  wire arith = i_alu_op == ccra_pkg::ALU_ADD || i_alu_op == ccra_pkg::ALU_SUB
    || i_alu_op == ccra_pkg::ALU_CMP;
  wire a_msb = i_alu_word ? aw[15] : aw[7];
  wire b_msb = i_alu_word ? bw[15] : bw[7];
  wire r_zero = res16 == 16'h0000;
  wire r_neg = i_alu_word ? res[15] : res[7];
  wire r_carry = arith && (i_alu_word ? res[16] : res[8]);
  wire same_in = (i_alu_op == ccra_pkg::ALU_ADD) ? a_msb == b_msb
    : a_msb != b_msb;
  wire r_ovf = arith && same_in && (r_neg != a_msb);

  // interrupt acceptance
  wire [1:0] mask = o_psw[ccra_pkg::IM_HI_BIT:ccra_pkg::IM_LO_BIT];
  wire maskable_irq_enable = o_psw[ccra_pkg::MIE_BIT];
  wire mask_ok = i_irq_req && maskable_irq_enable && (i_irq_level < mask);
  wire acc = run && !i_reti && (i_nmi_req || mask_ok);
  wire wr_psw = i_wr_en && i_wr_sel == ccra_pkg::SEL_PSW;
  wire alu_wins = i_alu_go && !i_reti && !acc && !wr_psw;

  always_comb
  begin
    next_psw = o_psw;
    if (i_reti)
      next_psw = i_pop_data;
    else if (acc)
      next_psw[ccra_pkg::IM_HI_BIT:ccra_pkg::IM_LO_BIT] =
        i_nmi_req ? ccra_pkg::NMI_MASK : i_irq_level;
    else if (wr_psw)
      next_psw = i_wr_data[7:0];
    else if (i_alu_go)
    begin
      next_psw[ccra_pkg::ZF_BIT] = r_zero;
      next_psw[ccra_pkg::CF_BIT] = r_carry;
      next_psw[ccra_pkg::NF_BIT] = r_neg;
      next_psw[ccra_pkg::VF_BIT] = r_ovf;
    end
    next_psw = next_psw & ccra_pkg::PSW_USED;
  end

  // stack
  wire push_ok = i_push && !acc;
  wire pop_ok = (i_pop || i_reti) && !acc && !i_push;
  always_comb
  begin
    next_sp = sp;
    if (acc || push_ok)
      next_sp = sp - 16'h0001;
    else if (pop_ok)
      next_sp = sp + 16'h0001;
    else if (i_wr_en && i_wr_sel == ccra_pkg::SEL_SP)
      next_sp = i_wr_data;
  end

  // data and pointer registers have no reset
  always_ff @(posedge i_clk)
  begin
    sp <= next_sp;
    if (i_wr_en)
    begin
      case (i_wr_sel)
        ccra_pkg::SEL_B0: gp[0] <= i_wr_data[7:0];
        ccra_pkg::SEL_B1: gp[1] <= i_wr_data[7:0];
        ccra_pkg::SEL_B2: gp[2] <= i_wr_data[7:0];
        ccra_pkg::SEL_B3: gp[3] <= i_wr_data[7:0];
        ccra_pkg::SEL_W0: {gp[1], gp[0]} <= i_wr_data;
        ccra_pkg::SEL_W1: {gp[3], gp[2]} <= i_wr_data;
        ccra_pkg::SEL_P0: ptr0 <= i_wr_data;
        ccra_pkg::SEL_P1: ptr1 <= i_wr_data;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (i_rd_sel)
      ccra_pkg::SEL_B0: rd_mux = {8'h00, gp[0]};
      ccra_pkg::SEL_B1: rd_mux = {8'h00, gp[1]};
      ccra_pkg::SEL_B2: rd_mux = {8'h00, gp[2]};
      ccra_pkg::SEL_B3: rd_mux = {8'h00, gp[3]};
      ccra_pkg::SEL_W0: rd_mux = {gp[1], gp[0]};
      ccra_pkg::SEL_W1: rd_mux = {gp[3], gp[2]};
      ccra_pkg::SEL_P0: rd_mux = ptr0;
      ccra_pkg::SEL_P1: rd_mux = ptr1;
      ccra_pkg::SEL_SP: rd_mux = sp;
      ccra_pkg::SEL_PSW: rd_mux = {8'h00, o_psw};
      default: rd_mux = 16'h0000;
    endcase
  end

  // effective address
  wire [15:0] base = i_ea_ptr ? ptr1 : ptr0;
  wire reuse = i_ea_mode == ccra_pkg::EA_REUSE;
  wire ea_bad = i_ea_go && reuse && !i_ea_move;
  always_comb
  begin
    case (i_ea_mode)
      ccra_pkg::EA_AN_D8: ea16 = base + {8'h00, i_ea_disp[7:0]};
      ccra_pkg::EA_AN_D16: ea16 = base + i_ea_disp;
      ccra_pkg::EA_SP_D4: ea16 = sp + {12'h000, i_ea_disp[3:0]};
      ccra_pkg::EA_SP_D8: ea16 = sp + {8'h00, i_ea_disp[7:0]};
      ccra_pkg::EA_SP_D16: ea16 = sp + i_ea_disp;
      ccra_pkg::EA_ABS: ea16 = i_ea_disp;
      ccra_pkg::EA_RAM_SHORT: ea16 = {8'h00, i_ea_disp[7:0]};
      default: ea16 = base;
    endcase
    if (i_ea_mode == ccra_pkg::EA_IO_SHORT)
      next_ea = ccra_pkg::SFR_LO + {10'h000, i_ea_disp[7:0]};
    else if (reuse)
      next_ea = last_ea;
    else
      next_ea = {2'h0, ea16};
  end

  logic hit_ram, hit_sfr, hit_rom, hit_opt;
  ccra_range #(.LO(ccra_pkg::RAM_LO), .HI(ccra_pkg::RAM_HI)) u_ram (
    .i_addr(next_ea), .o_hit(hit_ram));
  ccra_range #(.LO(ccra_pkg::SFR_LO), .HI(ccra_pkg::SFR_HI)) u_sfr (
    .i_addr(next_ea), .o_hit(hit_sfr));
  ccra_range #(.LO(ccra_pkg::ROM_LO), .HI(ccra_pkg::ROM_HI)) u_rom (
    .i_addr(next_ea), .o_hit(hit_rom));
  ccra_range #(.LO(ccra_pkg::ROM_OPT), .HI(ccra_pkg::ROM_OPT)) u_opt (
    .i_addr(next_ea), .o_hit(hit_opt));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_alu_result <= 16'h0000;
      o_psw <= ccra_pkg::PSW_RESET;
      o_rd_data <= 16'h0000;
      o_stack_we <= 1'b0;
      o_stack_addr <= 16'h0000;
      o_stack_wdata <= 8'h00;
      o_irq_accept <= 1'b0;
      o_ea <= 18'h00000;
      o_ea_region <= 4'h0;
      o_ea_bad <= 1'b0;
      last_ea <= 18'h00000;
    end
    else
    begin
      if (i_alu_go && i_alu_op != ccra_pkg::ALU_CMP)
        o_alu_result <= res16;
      o_psw <= next_psw;
      o_rd_data <= rd_mux;
      o_stack_we <= acc || push_ok;
      o_stack_addr <= (acc || push_ok) ? next_sp : sp;
      o_stack_wdata <= acc ? o_psw : i_wr_data[7:0];
      o_irq_accept <= acc;
      o_ea_bad <= ea_bad;
      if (i_ea_go && !ea_bad)
      begin
        o_ea <= next_ea;
        last_ea <= next_ea;
        o_ea_region <= {hit_opt, hit_rom, hit_sfr, hit_ram};
      end
    end
  end

  chk_fetch_empty: assert property (
    run && q_count == 2'h0 && !o_fetch_req |=> o_fetch_req)
    else $error("no fetch while queue empty");
  chk_ir_load: assert property (
    pop && q_count != 2'h0 |=> o_instr_reg == $past(q0))
    else $error("opcode not loaded from queue");
  chk_single_wait: assert property (
    o_wait |-> $past(q_count) == 2'h0 && $past(i_need_imm) ##1 !o_wait)
    else $error("wait longer than one cycle");
  chk_decode_ahead: assert property (
    ##1 o_decode_ctrl == $past(next_decode))
    else $error("decode not one cycle ahead");
  chk_boot_vector: assert property (
    state == ccra_pkg::ST_VEC1 |-> o_fetch_req
      && o_fetch_addr == ccra_pkg::VEC_ADDR)
    else $error("vector fetch address wrong");
  chk_psw_push: assert property (
    acc |=> o_stack_we && o_stack_wdata == $past(o_psw) && o_irq_accept)
    else $error("status word not pushed");
  chk_zero_neg: assert property (
    alu_wins |=> o_psw[ccra_pkg::ZF_BIT] == $past(r_zero)
      && o_psw[ccra_pkg::NF_BIT] == $past(r_neg))
    else $error("zero or negative flag wrong");
  chk_carry_ovf: assert property (
    alu_wins |=> o_psw[ccra_pkg::CF_BIT] == $past(r_carry)
      && o_psw[ccra_pkg::VF_BIT] == $past(r_ovf))
    else $error("carry or overflow flag wrong");
  chk_mask_gate: assert property (
    o_irq_accept && !$past(i_nmi_req) |-> $past(maskable_irq_enable)
      && $past(i_irq_level) < $past(mask))
    else $error("masked request accepted");
  chk_mask_load: assert property (
    o_irq_accept && !$past(i_nmi_req) && !$past(i_reti) |->
      mask == $past(i_irq_level) && maskable_irq_enable == $past(maskable_irq_enable))
    else $error("mask level not loaded");
  chk_io_short: assert property (
    i_ea_go && i_ea_mode == ccra_pkg::EA_IO_SHORT |=>
      o_ea == ccra_pkg::SFR_LO + {10'h000, $past(i_ea_disp[7:0])})
    else $error("io short address wrong");
  cov_flush_wait: cover property (i_flush ##1 i_need_imm ##1 o_wait);
  cov_irq: cover property (o_irq_accept ##[1:20] i_reti);
  cov_reuse: cover property (i_ea_go && !reuse ##2 i_ea_go && reuse);
endmodule

/* core/ccra_pkg.sv */
// constants, encodings and types shared by the cpu core datapath
package ccra_pkg;
  // memory map
  localparam logic [17:0] VEC_ADDR = 18'h04000;
  localparam logic [17:0] RAM_LO = 18'h00000;
  localparam logic [17:0] RAM_HI = 18'h001ff;
  localparam logic [17:0] ROM_LO = 18'h04000;
  localparam logic [17:0] ROM_HI = 18'h07ffe;
  localparam logic [17:0] ROM_OPT = 18'h07fff;
  localparam logic [17:0] SFR_LO = 18'h03f00;
  localparam logic [17:0] SFR_HI = 18'h03fff;
  // status word layout
  localparam int ZF_BIT = 0;
  localparam int CF_BIT = 1;
  localparam int NF_BIT = 2;
  localparam int VF_BIT = 3;
  localparam int IM_LO_BIT = 4;
  localparam int IM_HI_BIT = 5;
  localparam int MIE_BIT = 6;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] PSW_USED = 8'h7f;
  localparam logic [1:0] NMI_MASK = 2'h0;
  // queue
  localparam logic [1:0] QUEUE_DEPTH = 2'h2;
  localparam logic [18:0] BYTE_NIBBLES = 19'h00002;

  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_CMP, ALU_AND, ALU_OR,
    ALU_XOR, ALU_MOV} ccra_alu_type;
  typedef enum logic [3:0] {SEL_B0, SEL_B1, SEL_B2, SEL_B3, SEL_W0, SEL_W1,
    SEL_P0, SEL_P1, SEL_SP, SEL_PSW} ccra_sel_type;
  typedef enum logic [3:0] {EA_IND, EA_AN_D8, EA_AN_D16, EA_SP_D4, EA_SP_D8,
    EA_SP_D16, EA_ABS, EA_RAM_SHORT, EA_IO_SHORT, EA_REUSE} ccra_ea_type;
  typedef enum logic [2:0] {BR_D4, BR_D7, BR_D11, BR_D12, BR_D16,
    BR_ABS18} ccra_br_type;
  typedef enum {ST_VEC0, ST_VEC1, ST_VEC2, ST_RUN} ccra_state_type;
endpackage

/* core/ccra_range.sv */
// address window compare, one instance per memory area
`timescale 1ns/1ns
module ccra_range #(
  parameter logic [17:0] LO = 18'h00000,
  parameter logic [17:0] HI = 18'h00000
) (
  input wire logic [17:0] i_addr,
  output logic o_hit
);
  assign o_hit = (i_addr >= LO) && (i_addr <= HI);
endmodule

/* dv/ccra_rom_model.sv */
// rom partner: instruction bytes on the core fetch link
`timescale 1ns/1ns
module ccra_rom_model (
  input wire logic i_clk,
  input wire logic i_fetch_req,
  input wire logic [17:0] i_fetch_addr,
  output logic [7:0] o_fetch_data
);
  logic [7:0] last = 8'h00;

  function automatic logic [7:0] rom_byte(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // unrequested cycles show a toggling pattern, never the last byte
  always_comb
  begin
    if (i_fetch_req)
      o_fetch_data = rom_byte(i_fetch_addr);
    else
      o_fetch_data = ~last;
  end

  always_ff @(posedge i_clk)
  begin
    last <= o_fetch_data;
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the cpu core datapath with a rom partner
`timescale 1ns/1ns
module testbench;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_instr_last, i_need_imm, i_flush, i_br_h, i_alu_go, i_alu_word;
  logic i_wr_en, i_push, i_pop, i_reti, i_irq_req, i_nmi_req, i_ea_go;
  logic i_ea_ptr, i_ea_move;
  logic [1:0] i_irq_level;
  logic [2:0] i_br_mode, i_alu_op;
  logic [3:0] i_wr_sel, i_rd_sel, i_ea_mode, o_decode_ctrl, o_ea_region;
  logic [7:0] i_fetch_data, i_pop_data, o_instr_reg, o_psw, o_stack_wdata;
  logic [15:0] i_src_a, i_src_b, i_wr_data, i_ea_disp, o_alu_result;
  logic [15:0] o_rd_data, o_stack_addr, rv;
  logic [17:0] i_br_disp, o_fetch_addr, o_ea;
  logic [18:0] o_pc, pcv;
  logic o_fetch_req, o_wait, o_boot_done, o_irq_accept, o_stack_we;
  logic o_ea_bad, acc;
  logic [7:0] p;
  logic [3:0] f;
  logic [15:0] regv[3];
  int seed = 34;
  int n_fail = 0;
  int check_count = 0;
  int a, b, r, m, msb, op, exp_r, t, k;
  int bnd[8] = '{'h01ff, 'h0200, 'h3eff, 'h3f00, 'h3fff, 'h4000, 'h7ffe,
    'h7fff};

  ccra_core i_ccra_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_fetch_data(i_fetch_data), .i_instr_last(i_instr_last),
    .i_need_imm(i_need_imm), .i_flush(i_flush), .i_br_mode(i_br_mode),
    .i_br_disp(i_br_disp), .i_br_h(i_br_h), .i_alu_go(i_alu_go),
    .i_alu_op(i_alu_op), .i_alu_word(i_alu_word), .i_src_a(i_src_a),
    .i_src_b(i_src_b), .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel),
    .i_wr_data(i_wr_data), .i_rd_sel(i_rd_sel), .i_push(i_push),
    .i_pop(i_pop), .i_reti(i_reti), .i_pop_data(i_pop_data),
    .i_irq_req(i_irq_req), .i_irq_level(i_irq_level),
    .i_nmi_req(i_nmi_req), .i_ea_go(i_ea_go), .i_ea_mode(i_ea_mode),
    .i_ea_ptr(i_ea_ptr), .i_ea_move(i_ea_move), .i_ea_disp(i_ea_disp),
    .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
    .o_instr_reg(o_instr_reg), .o_decode_ctrl(o_decode_ctrl),
    .o_wait(o_wait), .o_pc(o_pc), .o_boot_done(o_boot_done),
    .o_alu_result(o_alu_result), .o_psw(o_psw), .o_rd_data(o_rd_data),
    .o_stack_we(o_stack_we), .o_stack_addr(o_stack_addr),
    .o_stack_wdata(o_stack_wdata), .o_irq_accept(o_irq_accept),
    .o_ea(o_ea), .o_ea_region(o_ea_region), .o_ea_bad(o_ea_bad));

  ccra_rom_model i_ccra_rom_model (.i_clk(i_clk), .i_fetch_req(o_fetch_req),
    .i_fetch_addr(o_fetch_addr), .o_fetch_data(i_fetch_data));

  always #50 i_clk = ~i_clk;

  task automatic step;
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk_val(input logic [18:0] got, input logic [18:0] exp,
    input string what);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    i_wr_en = 1'b1;
    i_wr_sel = sel;
    i_wr_data = d;
    step();
    i_wr_en = 1'b0;
    step();
  endtask

  task automatic rd(input logic [3:0] sel);
    i_rd_sel = sel;
    step();
    step();
    rv = o_rd_data;
  endtask

  function automatic int ea_exp(int md, int pb, int sp, int d);
    case (md)
      0: return pb;
      1: return (pb + (d & 'hff)) & 'hffff;
      2: return (pb + d) & 'hffff;
      3: return (sp + (d & 'hf)) & 'hffff;
      4: return (sp + (d & 'hff)) & 'hffff;
      5: return (sp + d) & 'hffff;
      6: return d;
      7: return d & 'hff;
      default: return 'h3f00 + (d & 'hff);
    endcase
  endfunction

  task automatic ea(input int md, input logic mv, input int d, input int x);
    logic [3:0] rg;
    rg = {x == 'h7fff, x >= 'h4000 && x <= 'h7ffe,
      x >= 'h3f00 && x <= 'h3fff, x <= 'h1ff};
    i_ea_go = 1'b1;
    i_ea_mode = md[3:0];
    i_ea_move = mv;
    i_ea_disp = d[15:0];
    step();
    i_ea_go = 1'b0;
    chk_val(o_ea, x[17:0], "ea");
    chk_val(o_ea_bad, md == 9 && !mv, "ea bad");
    if (md != 9)
      chk_val(o_ea_region, rg, "region");
    step();
  endtask

  initial
  begin
    #(4000 * 100);
    n_fail++;
    conclude();
  end

  initial
  begin
    {i_instr_last, i_need_imm, i_flush, i_br_h, i_alu_go, i_alu_word} = 0;
    {i_wr_en, i_push, i_pop, i_reti, i_irq_req, i_nmi_req, i_ea_go} = 0;
    {i_ea_ptr, i_ea_move, i_br_mode, i_alu_op, i_wr_sel, i_rd_sel} = 0;
    {i_ea_mode, i_pop_data, i_src_a, i_src_b, i_wr_data, i_ea_disp} = 0;
    {i_br_disp, i_irq_level} = 0;
    repeat (20) step();
    chk_val(o_psw, ccra_pkg::PSW_RESET, "psw reset");
    i_sys_rst = 1'b0;
    t = 0;
    while (o_fetch_req !== 1'b1 && t < 8)
    begin
      step();
      t++;
    end
    chk_val(o_fetch_addr, ccra_pkg::VEC_ADDR, "vector lo");
    step();
    chk_val(o_fetch_addr, ccra_pkg::VEC_ADDR + 18'h1, "vector hi");
    step();
    pcv = {2'b00, i_ccra_rom_model.rom_byte(18'h04001),
      i_ccra_rom_model.rom_byte(18'h04000), 1'b0};
    chk_val(o_pc, pcv, "reset pc");
    chk_val(o_boot_done, 1'b1, "booted");
    // relative branch backwards by six nibbles, then empty queue wait
    i_flush = 1'b1;
    i_br_disp = 18'h0000a;
    step();
    i_flush = 1'b0;
    i_need_imm = 1'b1;
    pcv = pcv - 19'h00006;
    chk_val(o_fetch_req, 1'b1, "fetch");
    chk_val(o_fetch_addr, pcv[18:1], "branch rel");
    step();
    i_need_imm = 1'b0;
    chk_val(o_wait, 1'b1, "wait");
    chk_val(o_fetch_addr, pcv[18:1] + 18'h1, "next fetch");
    step();
    chk_val(o_wait, 1'b0, "wait once");
    chk_val(o_fetch_req, 1'b0, "queue full");
    i_flush = 1'b1;
    i_br_mode = 3'h5;
    i_br_disp = 18'h05123;
    i_br_h = 1'b1;
    step();
    i_flush = 1'b0;
    i_br_h = 1'b0;
    chk_val(o_fetch_addr, 18'h05123, "branch abs");
    step();
    i_instr_last = 1'b1;
    step();
    i_instr_last = 1'b0;
    p = i_ccra_rom_model.rom_byte(18'h05123);
    chk_val(o_instr_reg, p, "ir");
    chk_val(o_decode_ctrl, 4'h1 << p[7:6], "decode");
    chk_val(o_pc, {18'h05123, 1'b1}, "pc half");
    chk_val(o_fetch_req, 1'b1, "refill");
    for (int md = 0; md < 5; md++)
    begin
      k = (md < 2) ? 4 + 3 * md : (md == 4 ? 16 : 9 + md);
      b = $random(seed);
      a = b & ((1 << k) - 1);
      if (a >> (k - 1))
        a = a - (1 << k);
      i_flush = 1'b1;
      i_br_mode = md[2:0];
      i_br_disp = b[17:0];
      step();
      i_flush = 1'b0;
      t = ('h0a247 + a) & 'h7ffff;
      chk_val(o_fetch_addr, t >> 1, "branch disp");
      step();
    end
    wr(4'h0, 16'h0011);
    wr(4'h1, 16'h0022);
    rd(4'h4);
    chk_val(rv, 16'h2211, "pair");
    wr(4'h5, 16'habcd);
    rd(4'h2);
    chk_val(rv[7:0], 8'hcd, "byte2");
    rd(4'h3);
    chk_val(rv[7:0], 8'hab, "byte3");
    for (int s = 0; s < 3; s++)
    begin
      regv[s] = $random(seed);
      wr(4'h6 + s[3:0], regv[s]);
      rd(4'h6 + s[3:0]);
      chk_val(rv, regv[s], "pointer");
    end
    for (int md = 0; md < 9; md++)
    begin
      k = $random(seed) & 1;
      i_ea_ptr = k[0];
      a = $random(seed) & 'hffff;
      ea(md, 1'b1, a, ea_exp(md, regv[k], regv[2], a));
    end
    foreach (bnd[j])
      ea(6, 1'b1, bnd[j], bnd[j]);
    ea(9, 1'b1, 'h1234, 'h7fff);
    ea(9, 1'b0, 'h1234, 'h7fff);
    wr(4'h8, 16'h0100);
    i_push = 1'b1;
    i_wr_data = 16'h003c;
    step();
    i_push = 1'b0;
    chk_val(o_stack_we, 1'b1, "push we");
    chk_val(o_stack_addr, 16'h00ff, "push addr");
    chk_val(o_stack_wdata, 8'h3c, "push data");
    rd(4'h8);
    chk_val(rv, 16'h00ff, "sp push");
    i_pop = 1'b1;
    step();
    i_pop = 1'b0;
    rd(4'h8);
    chk_val(rv, 16'h0100, "sp pop");
    exp_r = 0;
    for (int j = 0; j < 48; j++)
    begin
      op = $unsigned($random(seed)) % 7;
      m = j[0] ? 'hffff : 'hff;
      msb = j[0] ? 15 : 7;
      a = $random(seed) & m;
      b = (j % 8 == 2) ? a : $random(seed) & m;
      case (op)
        0: r = a + b;
        1, 2: r = a - b;
        3: r = a & b;
        4: r = a | b;
        5: r = a ^ b;
        default: r = b;
      endcase
      f[1] = op == 0 ? r > m : (op < 3 ? a < b : 0);
      r = r & m;
      f[0] = r == 0;
      f[2] = (r >> msb) & 1;
      f[3] = op == 0 ? (((a ^ r) & (b ^ r)) >> msb) & 1 :
        (op < 3 ? (((a ^ b) & (a ^ r)) >> msb) & 1 : 0);
      if (op != 2)
        exp_r = r;
      i_alu_go = 1'b1;
      i_alu_word = j[0];
      i_alu_op = op[2:0];
      i_src_a = a[15:0];
      i_src_b = b[15:0];
      step();
      i_alu_go = 1'b0;
      chk_val(o_alu_result & m[15:0], exp_r & m, "alu");
      chk_val(o_psw[3:0], f, "flags");
      step();
    end
    for (int q = 0; q < 32; q++)
    begin
      p = {1'b0, q[4:2], 4'h5};
      acc = q[4] && (q[1:0] < q[3:2]);
      wr(4'h8, 16'h0180);
      wr(4'h9, {8'h00, p});
      i_irq_req = 1'b1;
      i_irq_level = q[1:0];
      step();
      i_irq_req = 1'b0;
      chk_val(o_irq_accept, acc, "accept");
      if (acc)
      begin
        chk_val(o_stack_addr, 16'h017f, "irq sp");
        chk_val(o_stack_wdata, p, "psw saved");
        chk_val(o_psw, {p[7:6], q[1:0], p[3:0]}, "mask");
      end
      i_reti = 1'b1;
      i_pop_data = p;
      step();
      i_reti = 1'b0;
      chk_val(o_psw, p, "restore");
      step();
    end
    wr(4'h9, 16'h0035);
    i_nmi_req = 1'b1;
    step();
    i_nmi_req = 1'b0;
    chk_val(o_irq_accept, 1'b1, "nmi");
    chk_val(o_psw, 8'h05, "nmi mask");
    step();
    conclude();
  end
endmodule
